// file: design/modbus_defs.vh
/*
  Constants of the field-bus slave request handler: function and
  exception codes, register ID map, command word bits, CRC and timing.
  Assumes inclusion by every design file; definitions only.
*/
`ifndef MODBUS_DEFS_VH
`define MODBUS_DEFS_VH

`define CLK_PERIOD_NS   8
// 3.5 characters of 11 bits at 9600 baud
`define GAP_TIME_NS     4010417

`define FC_READ_HOLD    8'h03
`define FC_READ_INPUT   8'h04
`define FC_WRITE_ONE    8'h06
`define FC_WRITE_MANY   8'h10
`define EXC_FLAG        8'h80
`define EXC_ILL_FUNC    8'h01
`define EXC_ILL_ADDR    8'h02
`define EXC_ILL_VALUE   8'h03
`define EXC_DEV_FAIL    8'h04
`define EXC_DEV_BUSY    8'h06
`define BCAST_ADDR      8'h00

`define MAX_REGS        16'h000B
`define IN_BASE_ID      16'h07D1
`define OUT_BASE_ID     16'h0835
`define SPEED_ID_OFS    16'h0002
`define SPEED_MAX       16'h2710

`define CW_RUN          0
`define CW_REVERSE      1
`define CW_FAULT_RESET  2
`define CW_COAST        3
`define CW_RAMP         4
`define CW_FAST_RAMP    5
`define CW_FREEZE       6
`define CW_ZERO         7
`define CW_BUS_CTRL     8
`define CW_BUS_SETP     9
`define CW_BLOCK        12
`define CW_DIG_OUT      13
`define FUNC_SEL_BUS    8'h1C
`define STOP_RAMP       1'b0
`define STOP_COAST      1'b1

`define CRC_INIT        16'hFFFF
`define CRC_POLY        16'hA001
`define CNT_RESET       16'h0000

`endif

// file: design/crc16_unit.v
/*
  Byte-serial reflected CRC-16 register.
  Assumes one byte per enabled cycle; clear has priority over update.
*/
`include "modbus_defs.vh"

module crc16_unit (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        clr,
  input  wire        en,
  input  wire [7:0]  data_in,
  output reg  [15:0] crc_out
);

  function [15:0] crc_step;
    input [15:0] c;
    input [7:0]  d;
    integer      i;
    reg   [15:0] t;
    begin
      t = c ^ {8'h00, d};
      for (i = 0; i < 8; i = i + 1) begin
        t = t[0] ? ((t >> 1) ^ `CRC_POLY) : (t >> 1);
      end
      crc_step = t;
    end
  endfunction

  always @(posedge sys_clk) begin
    if (rst) begin
      crc_out <= `CRC_INIT;
    end else if (ce) begin
      if (clr) begin
        crc_out <= `CRC_INIT;
      end else if (en) begin
        crc_out <= crc_step(crc_out, data_in);
      end
    end
  end

endmodule

// file: design/cmd_word_decoder.v
/*
  Turns the fieldbus command word and speed setpoint into drive commands.
  Assumes words written by the request handler; stop mode from a setting.
*/
`include "modbus_defs.vh"

module cmd_word_decoder (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        ce,
  input  wire [15:0] cmd_word,
  input  wire [15:0] setpoint_word,
  input  wire        stop_mode_setting,
  input  wire [7:0]  relay1_function_select,
  input  wire [7:0]  relay2_function_select,
  input  wire [7:0]  transistor_out_function_select,
  output reg         run_cmd,
  output reg         forward_rotation,
  output reg         reverse_rotation,
  output reg         fault_reset,
  output reg         stop_mode,
  output reg         fast_ramp,
  output reg         force_bus_control,
  output reg         force_bus_setpoint,
  output reg         inverter_block,
  output reg         relay_output_1,
  output reg         relay_output_2,
  output reg         transistor_output,
  output reg  [15:0] speed_setpoint
);

  reg run_inhibit_reg;

  function bus_driven;
    input [7:0] sel;
    begin
      bus_driven = (sel == `FUNC_SEL_BUS);
    end
  endfunction

  always @(posedge sys_clk) begin
    if (rst) begin
      run_inhibit_reg    <= 1'b0;
      run_cmd            <= 1'b0;
      forward_rotation   <= 1'b1;
      reverse_rotation   <= 1'b0;
      fault_reset        <= 1'b0;
      stop_mode          <= `STOP_RAMP;
      fast_ramp          <= 1'b0;
      force_bus_control  <= 1'b0;
      force_bus_setpoint <= 1'b0;
      inverter_block     <= 1'b0;
      relay_output_1     <= 1'b0;
      relay_output_2     <= 1'b0;
      transistor_output  <= 1'b0;
      speed_setpoint     <= 16'h0000;
    end else if (ce) begin
      // Block holds off run until run bit drops and rises again
      if (cmd_word[`CW_BLOCK])
        run_inhibit_reg <= 1'b1;
      else if (!cmd_word[`CW_RUN])
        run_inhibit_reg <= 1'b0;
      run_cmd <= cmd_word[`CW_RUN] & ~cmd_word[`CW_BLOCK] &
                 ~run_inhibit_reg;
      inverter_block   <= cmd_word[`CW_BLOCK];
      reverse_rotation <= cmd_word[`CW_REVERSE];
      forward_rotation <= ~cmd_word[`CW_REVERSE];
      fault_reset      <= cmd_word[`CW_FAULT_RESET];
      // Coast wins when both override bits are set
      if (cmd_word[`CW_COAST])
        stop_mode <= `STOP_COAST;
      else if (cmd_word[`CW_RAMP])
        stop_mode <= `STOP_RAMP;
      else
        stop_mode <= stop_mode_setting;
      fast_ramp          <= cmd_word[`CW_FAST_RAMP];
      force_bus_control  <= cmd_word[`CW_BUS_CTRL];
      force_bus_setpoint <= cmd_word[`CW_BUS_SETP];
      if (cmd_word[`CW_ZERO])
        speed_setpoint <= 16'h0000;
      else if (!cmd_word[`CW_FREEZE])
        speed_setpoint <= setpoint_word;
      relay_output_1 <= bus_driven(relay1_function_select) &
                        cmd_word[`CW_DIG_OUT];
      relay_output_2 <= bus_driven(relay2_function_select) &
                        cmd_word[`CW_DIG_OUT];
      transistor_output <= bus_driven(transistor_out_function_select) &
                           cmd_word[`CW_DIG_OUT];
    end
  end

endmodule

// file: design/modbus_rtu_slave_handler.v
/*
  Request handler of the field-bus slave: collects a frame, checks it,
  executes register reads and writes and sends the reply or exception.
  Assumes a character engine that delivers received bytes with an error
  flag and accepts transmit bytes on a valid/ready handshake.
*/
`include "modbus_defs.vh"

module modbus_rtu_slave_handler #(
  parameter DEPTH      = 32,
  parameter NREGS      = 11,
  parameter CNT_W      = 20,
  parameter GAP_CYCLES = (`GAP_TIME_NS + `CLK_PERIOD_NS - 1) /
                         `CLK_PERIOD_NS
) (
  input  wire              sys_clk,
  input  wire              rst,
  input  wire              ce,
  input  wire [7:0]        station_address,
  input  wire [7:0]        rx_data,
  input  wire              rx_valid,
  input  wire              rx_err,
  output reg  [7:0]        tx_data,
  output wire              tx_valid,
  input  wire              tx_ready,
  input  wire [NREGS*16-1:0] status_words,
  input  wire              busy,
  input  wire              exec_fail,
  input  wire              stop_mode_setting,
  input  wire [7:0]        relay1_function_select,
  input  wire [7:0]        relay2_function_select,
  input  wire [7:0]        transistor_out_function_select,
  output reg  [15:0]       crc_error_counter,
  output reg               comm_length_fault,
  output wire [NREGS*16-1:0] process_data_out,
  output wire              run_cmd,
  output wire              forward_rotation,
  output wire              reverse_rotation,
  output wire              fault_reset,
  output wire              stop_mode,
  output wire              fast_ramp,
  output wire              force_bus_control,
  output wire              force_bus_setpoint,
  output wire              inverter_block,
  output wire              relay_output_1,
  output wire              relay_output_2,
  output wire              transistor_output,
  output wire [15:0]       speed_setpoint
);

  localparam [4:0] S_RX    = 5'b00001;
  localparam [4:0] S_CHECK = 5'b00010;
  localparam [4:0] S_LOAD  = 5'b00100;
  localparam [4:0] S_SEND  = 5'b01000;
  localparam [4:0] S_IDLE  = 5'b10000;
  localparam [CNT_W-1:0] GAP = GAP_CYCLES[CNT_W-1:0];

  reg [4:0]       state_reg;
  reg [7:0]       frame_mem [0:DEPTH-1];
  reg [15:0]      pd_mem [0:NREGS-1];
  reg [5:0]       rx_len_reg;
  reg             frame_bad_reg;
  reg [CNT_W-1:0] idle_cnt_reg;
  reg [5:0]       idx_reg;
  reg [5:0]       body_len_reg;
  reg [5:0]       total_len_reg;
  reg             echo_reg;
  reg             exc_reg;
  reg [7:0]       exc_code_reg;
  reg             src_out_reg;
  reg [15:0]      rd_off_reg;
  reg [15:0]      rd_qty_reg;
  wire [15:0]     crc_val;

  // Frame fields
  wire [7:0]  f_addr  = frame_mem[0];
  wire [7:0]  f_func  = frame_mem[1];
  wire [15:0] f_reg   = {frame_mem[2], frame_mem[3]};
  wire [15:0] f_val   = {frame_mem[4], frame_mem[5]};
  wire [15:0] f_id    = f_reg + 16'h0001;
  wire        f_bcast = (f_addr == `BCAST_ADDR);
  wire        f_wr1   = (f_func == `FC_WRITE_ONE);
  wire        f_wrn   = (f_func == `FC_WRITE_MANY);
  wire        f_rd    = (f_func == `FC_READ_HOLD) ||
                        (f_func == `FC_READ_INPUT);
  wire [15:0] f_qty   = f_wr1 ? 16'h0001 : f_val;
  wire [15:0] in_off  = f_id - `IN_BASE_ID;
  wire [15:0] out_off = f_id - `OUT_BASE_ID;
  wire        in_ok   = (f_id >= `IN_BASE_ID) &&
                        (in_off + f_qty <= `MAX_REGS);
  wire        out_ok  = (f_id >= `OUT_BASE_ID) &&
                        (out_off + f_qty <= `MAX_REGS);
  wire [5:0]  wrn_len = 6'd9 + {f_qty[4:0], 1'b0};

  function [7:0] frame_byte;
    input [15:0] i;
    begin
      frame_byte = (i < DEPTH) ? frame_mem[i[4:0]] : 8'h00;
    end
  endfunction

  // Word k of the write data, bound for process data slot in_off + k
  function [15:0] new_word;
    input [15:0] k;
    reg   [15:0] b;
    begin
      b = 16'h0007 + {k[14:0], 1'b0};
      new_word = f_wr1 ? f_val : {frame_byte(b), frame_byte(b + 16'h0001)};
    end
  endfunction

  reg         len_ok;
  reg         val_ok;
  reg [15:0]  k;
  integer     i;
  integer     j;

  always @* begin
    len_ok = 1'b0;
    if (f_rd)
      len_ok = (rx_len_reg == 6'd8) && (f_qty != 16'h0000) &&
               (f_qty <= `MAX_REGS);
    else if (f_wr1)
      len_ok = (rx_len_reg == 6'd8);
    else if (f_wrn)
      len_ok = (f_qty != 16'h0000) && (f_qty <= `MAX_REGS) &&
               (frame_mem[6] == {f_qty[6:0], 1'b0}) &&
               (rx_len_reg == wrn_len);
    val_ok = 1'b1;
    k = 16'h0000;
    for (i = 0; i < NREGS; i = i + 1) begin
      k = i[15:0] - in_off;
      if (i[15:0] == `SPEED_ID_OFS && i[15:0] >= in_off &&
          k < f_qty && new_word(k) > `SPEED_MAX)
        val_ok = 1'b0;
    end
  end

  wire        fresh_frame = (rx_len_reg == 6'd0);
  wire        crc_clr = (state_reg == S_CHECK) ||
                        ((state_reg == S_LOAD) && idx_reg == total_len_reg);
  wire        rx_take = (state_reg == S_RX) && rx_valid;
  wire        tx_take = (state_reg == S_SEND) && tx_ready;
  wire        crc_en  = rx_take || (tx_take && idx_reg < body_len_reg);

  assign tx_valid = (state_reg == S_SEND);

  crc16_unit u_crc (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .clr     (crc_clr),
    .en      (crc_en),
    .data_in (rx_take ? rx_data : tx_data),
    .crc_out (crc_val)
  );

  // Byte of the reply body at position n
  function [7:0] reply_byte;
    input [5:0] n;
    reg   [15:0] w;
    reg   [15:0] slot;
    reg   [5:0]  pos;
    begin
      // Data words start after address, code and byte count
      pos  = n - 6'd3;
      slot = rd_off_reg + {11'd0, pos[5:1]};
      if (slot < NREGS)
        w = src_out_reg ? status_words[slot[3:0]*16 +: 16]
                        : pd_mem[slot[3:0]];
      else
        w = 16'h0000;
      if (echo_reg)
        reply_byte = frame_mem[n[4:0]];
      else if (n == 6'd0)
        reply_byte = f_addr;
      else if (n == 6'd1)
        reply_byte = exc_reg ? (f_func | `EXC_FLAG) : f_func;
      else if (n == 6'd2)
        reply_byte = exc_reg ? exc_code_reg
                             : {rd_qty_reg[6:0], 1'b0};
      else
        reply_byte = n[0] ? w[15:8] : w[7:0];
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < NREGS; g = g + 1) begin : pd_out
      assign process_data_out[g*16 +: 16] = pd_mem[g];
    end
  endgenerate

  always @(posedge sys_clk) begin
    if (rst) begin
      state_reg         <= S_RX;
      rx_len_reg        <= 6'd0;
      frame_bad_reg     <= 1'b0;
      idle_cnt_reg      <= {CNT_W{1'b0}};
      idx_reg           <= 6'd0;
      body_len_reg      <= 6'd0;
      total_len_reg     <= 6'd0;
      echo_reg          <= 1'b0;
      exc_reg           <= 1'b0;
      exc_code_reg      <= 8'h00;
      src_out_reg       <= 1'b0;
      rd_off_reg        <= 16'h0000;
      rd_qty_reg        <= 16'h0000;
      tx_data           <= 8'h00;
      crc_error_counter <= `CNT_RESET;
      comm_length_fault <= 1'b0;
      for (j = 0; j < NREGS; j = j + 1)
        pd_mem[j] <= 16'h0000;
      for (j = 0; j < DEPTH; j = j + 1)
        frame_mem[j] <= 8'h00;
    end else if (ce) begin
      if (rx_valid || tx_take)
        idle_cnt_reg <= {CNT_W{1'b0}};
      else if (idle_cnt_reg < GAP)
        idle_cnt_reg <= idle_cnt_reg + 1'b1;
      if (fault_reset)
        comm_length_fault <= 1'b0;
      case (state_reg)
        S_RX: begin
          if (rx_valid) begin
            if (rx_len_reg < DEPTH)
              frame_mem[rx_len_reg[4:0]] <= rx_data;
            else
              frame_bad_reg <= 1'b1;
            if (rx_len_reg != 6'd63)
              rx_len_reg <= rx_len_reg + 6'd1;
            if (rx_err)
              frame_bad_reg <= 1'b1;
            if (fresh_frame && idle_cnt_reg < GAP)
              frame_bad_reg <= 1'b1;
          end else if (!fresh_frame && idle_cnt_reg >= GAP) begin
            // Frame closes only after 3.5 characters of silence
            state_reg <= S_CHECK;
          end
        end
        S_CHECK: begin
          state_reg    <= S_IDLE;
          exc_reg      <= 1'b0;
          echo_reg     <= 1'b0;
          idx_reg      <= 6'd0;
          src_out_reg  <= out_ok;
          rd_off_reg   <= out_ok ? out_off : in_off;
          rd_qty_reg   <= f_qty;
          body_len_reg <= 6'd3;
          total_len_reg <= 6'd5;
          if (frame_bad_reg || rx_len_reg < 6'd4) begin
            state_reg <= S_IDLE;
          end else if (crc_val != 16'h0000) begin
            crc_error_counter <= crc_error_counter + 16'h0001;
          end else if (f_addr != station_address && !f_bcast) begin
            state_reg <= S_IDLE;
          end else if (!(f_rd || f_wr1 || f_wrn)) begin
            exc_reg      <= 1'b1;
            exc_code_reg <= `EXC_ILL_FUNC;
            state_reg    <= f_bcast ? S_IDLE : S_LOAD;
          end else if (!len_ok) begin
            comm_length_fault <= 1'b1;
          end else begin
            exc_reg <= 1'b1;
            if (busy)
              exc_code_reg <= `EXC_DEV_BUSY;
            else if (exec_fail)
              exc_code_reg <= `EXC_DEV_FAIL;
            else if (!(in_ok || (f_rd && out_ok)))
              exc_code_reg <= `EXC_ILL_ADDR;
            else if (!f_rd && !val_ok)
              exc_code_reg <= `EXC_ILL_VALUE;
            else begin
              exc_reg <= 1'b0;
              if (!f_rd) begin
                for (j = 0; j < NREGS; j = j + 1) begin
                  if (j[15:0] >= in_off && j[15:0] - in_off < f_qty)
                    pd_mem[j] <= new_word(j[15:0] - in_off);
                end
                echo_reg      <= 1'b1;
                body_len_reg  <= rx_len_reg;
                total_len_reg <= rx_len_reg;
              end else begin
                body_len_reg  <= 6'd3 + {f_qty[4:0], 1'b0};
                total_len_reg <= 6'd5 + {f_qty[4:0], 1'b0};
              end
            end
            state_reg <= f_bcast ? S_IDLE : S_LOAD;
          end
        end
        S_LOAD: begin
          if (idx_reg == total_len_reg) begin
            state_reg <= S_IDLE;
          end else begin
            if (idx_reg < body_len_reg)
              tx_data <= reply_byte(idx_reg);
            else if (idx_reg == body_len_reg)
              tx_data <= crc_val[7:0];
            else
              tx_data <= crc_val[15:8];
            state_reg <= S_SEND;
          end
        end
        S_SEND: begin
          if (tx_ready) begin
            idx_reg   <= idx_reg + 6'd1;
            state_reg <= S_LOAD;
          end
        end
        S_IDLE: begin
          // Back to listening; master retries on its own timeout
          rx_len_reg    <= 6'd0;
          frame_bad_reg <= 1'b0;
          state_reg     <= S_RX;
        end
        default: begin
          state_reg <= S_RX;
        end
      endcase
    end
  end

  cmd_word_decoder u_dec (
    .sys_clk                        (sys_clk),
    .rst                            (rst),
    .ce                             (ce),
    .cmd_word                       (pd_mem[0]),
    .setpoint_word                  (pd_mem[2]),
    .stop_mode_setting              (stop_mode_setting),
    .relay1_function_select         (relay1_function_select),
    .relay2_function_select         (relay2_function_select),
    .transistor_out_function_select (transistor_out_function_select),
    .run_cmd                        (run_cmd),
    .forward_rotation               (forward_rotation),
    .reverse_rotation               (reverse_rotation),
    .fault_reset                    (fault_reset),
    .stop_mode                      (stop_mode),
    .fast_ramp                      (fast_ramp),
    .force_bus_control              (force_bus_control),
    .force_bus_setpoint             (force_bus_setpoint),
    .inverter_block                 (inverter_block),
    .relay_output_1                 (relay_output_1),
    .relay_output_2                 (relay_output_2),
    .transistor_output              (transistor_output),
    .speed_setpoint                 (speed_setpoint)
  );

endmodule

// file: verif/slave_handler_asserts.sv
/* Port checker of the field-bus slave handler.
   Assumes a bind onto the handler top, gap and word count passed on. */
`include "modbus_defs.vh"
module slave_handler_asserts #(
  parameter GAP_CYCLES = 20,
  parameter NREGS      = 11
) (
  input logic                  sys_clk,
  input logic                  rst,
  input logic                  ce,
  input logic [7:0]            station_address,
  input logic [7:0]            rx_data,
  input logic                  rx_valid,
  input logic [7:0]            tx_data,
  input logic                  tx_valid,
  input logic                  tx_ready,
  input logic                  stop_mode_setting,
  input logic [15:0]           crc_error_counter,
  input logic [NREGS*16-1:0]   process_data_out,
  input logic                  forward_rotation,
  input logic                  reverse_rotation,
  input logic                  stop_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  int unsigned idle;
  logic [5:0]  nrx;
  logic [7:0]  fc_q;
  logic [3:0]  ntx;
  logic        exc;
  wire  [15:0] w = process_data_out[15:0];
  wire         ok_fc = fc_q inside {8'h03, 8'h04, 8'h06, 8'h10};
  // Frame start is judged by rx silence only, as the master sees it
  always @(posedge sys_clk) begin
    if (rst) begin
      idle <= 0;
      nrx  <= 6'h0;
      ntx  <= 4'h0;
      exc  <= 1'b0;
    end else if (ce) begin
      idle <= rx_valid ? 0 : idle + 1;
      if (rx_valid) begin
        nrx <= (idle >= GAP_CYCLES) ? 6'h1 : nrx + 6'h1;
        ntx <= 4'h0;
        if (nrx == 6'h1) fc_q <= rx_data;
      end else if (tx_valid && tx_ready) begin
        ntx <= ntx + 4'h1;
        if (ntx == 4'h1) exc <= tx_data[7];
      end
    end
  end
  sequence s_start;
    tx_valid && ntx == 4'h0;
  endsequence
  sequence s_live;
    $past(ce) && !$past(rst);
  endsequence
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("tx byte withdrawn");
  property p_gap;
    s_start |-> idle >= GAP_CYCLES;
  endproperty
  a_gap: assert property (p_gap) else $error("reply too early");
  property p_addr;
    s_start |-> tx_data == station_address && tx_data != 8'h00;
  endproperty
  a_addr: assert property (p_addr) else $error("bad reply addr");
  property p_exc;
    tx_valid && ntx == 4'h1 && tx_data[7] |-> tx_data == (fc_q | 8'h80);
  endproperty
  a_exc: assert property (p_exc) else $error("bad exception fc");
  property p_code;
    tx_valid && ntx == 4'h2 && exc |-> (ok_fc ?
      tx_data inside {8'h02, 8'h03, 8'h04, 8'h06} : tx_data == 8'h01);
  endproperty
  a_code: assert property (p_code) else $error("bad code");
  property p_cnt;
    s_live ##0 $changed(crc_error_counter) |->
      crc_error_counter == $past(crc_error_counter) + 16'h0001;
  endproperty
  a_cnt: assert property (p_cnt) else $error("counter step");
  property p_dir;
    s_live |-> reverse_rotation == $past(w[1]) &&
      forward_rotation != reverse_rotation;
  endproperty
  a_dir: assert property (p_dir) else $error("direction");
  property p_stop;
    s_live |-> stop_mode == ($past(w[3]) ||
      !$past(w[4]) && $past(stop_mode_setting));
  endproperty
  a_stop: assert property (p_stop) else $error("stop mode");
endmodule

// file: verif/plc_master.sv
/* Bus master model: sends request frames, collects reply bytes.
   Assumes the bench calls send and reads got between frames. */
module plc_master (
  input  logic       sys_clk,
  input  logic [7:0] tx_data,
  input  logic       tx_valid,
  output logic [7:0] rx_data,
  output logic       rx_valid,
  output logic       rx_err,
  output logic       tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  int         slow = 0;
  int         ph = 0;
  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    rx_err   = 1'b0;
    tx_ready = 1'b0;
  end
  // Slow mode grants one cycle in three so bytes must be held
  always @(negedge sys_clk) begin
    ph <= ph + 1;
    tx_ready <= slow == 0 || ph % 3 == 0;
  end
  always @(posedge sys_clk)
    if (tx_valid && tx_ready) got.push_back(tx_data);
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  // Idle line shows the inverted last byte, never a stale copy
  task automatic send(input logic [7:0] f[$], input logic [3:0] md);
    logic [15:0] c;
    c = crc16(f) ^ {15'h0000, md == 4'h2};
    f = {f, c[7:0], c[15:8]};
    foreach (f[i]) begin
      @(negedge sys_clk);
      rx_data  <= f[i];
      rx_valid <= 1'b1;
      rx_err   <= md == 4'h1 && i == 1;
      @(negedge sys_clk);
      rx_valid <= 1'b0;
      rx_err   <= 1'b0;
      rx_data  <= ~f[i];
    end
  endtask
endmodule

// file: verif/modbus_rtu_slave_handler_tb_top.sv
/* Self-checking bench of the field-bus slave handler.
   Assumes the master model and checker are compiled before it. */
module modbus_rtu_slave_handler_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int GAP = 20;
  logic         sys_clk = 1'b0;
  logic         rst = 1'b1;
  logic         busy = 1'b0;
  logic         exec_fail = 1'b0;
  logic         stop_mode_setting = 1'b0;
  logic [7:0]   relay1_function_select = 8'h00;
  logic [175:0] status_words;
  wire  [7:0]   rx_data, tx_data;
  wire          rx_valid, rx_err, tx_valid, tx_ready, comm_length_fault;
  wire  [15:0]  crc_error_counter, speed_setpoint;
  wire  [175:0] process_data_out;
  wire          run_cmd, forward_rotation, reverse_rotation, stop_mode;
  wire          inverter_block, relay_output_1;
  wire          fast_ramp, force_bus_control, force_bus_setpoint;
  int           n_errors = 0;
  int           n_checks = 0;
  // Row: addr fc, register, value, mode kind, data
  localparam logic [79:0] ROWS [17] = '{
    80'h0106_07D0_0281_0100_0000,
    80'h0103_07D0_0001_0200_0281,
    80'h0104_07D0_0001_0200_0281,
    80'h0104_0836_0001_0200_2102,
    80'h0106_0802_0001_0300_0002,
    80'h0106_0834_0001_0300_0002,
    80'h0107_07D0_0001_0300_0001,
    80'h0106_07D2_2711_0300_0003,
    80'h0106_07D2_2710_0100_0000,
    80'h0103_07D0_0001_3300_0006,
    80'h0103_07D0_0001_4300_0004,
    80'h0203_07D0_0001_0000_0000,
    80'h0103_07D0_0001_1000_0000,
    80'h0103_07D0_0001_2000_0000,
    80'h0103_07D0_000C_0000_0000,
    80'h0006_07D0_0003_0000_0000,
    80'h0110_07D1_0001_0100_1234
  };
  modbus_rtu_slave_handler #(.GAP_CYCLES(GAP)) uut (
    .sys_clk, .rst, .ce(1'b1), .station_address(8'h01), .rx_data,
    .rx_valid, .rx_err, .tx_data, .tx_valid, .tx_ready, .status_words,
    .busy, .exec_fail, .stop_mode_setting, .relay1_function_select,
    .relay2_function_select(8'h00), .transistor_out_function_select(8'h00),
    .crc_error_counter, .comm_length_fault, .process_data_out, .run_cmd,
    .forward_rotation, .reverse_rotation, .fault_reset(), .stop_mode,
    .fast_ramp, .force_bus_control, .force_bus_setpoint,
    .inverter_block, .relay_output_1, .relay_output_2(),
    .transistor_output(), .speed_setpoint
  );
  plc_master m (
    .sys_clk, .tx_data, .tx_valid, .rx_data, .rx_valid, .rx_err, .tx_ready
  );
  initial forever #4 sys_clk = ~sys_clk;
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    n_checks++;
    if (g !== x) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic chkf(input logic [7:0] x[$]);
    chk(16'(m.got.size()), 16'(x.size()));
    foreach (x[i])
      if (i < m.got.size()) chk({8'h00, m.got[i]}, {8'h00, x[i]});
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic xfer(input logic [79:0] r);
    logic [7:0]  q[$];
    logic [7:0]  e[$];
    logic [15:0] x;
    logic [15:0] c;
    int          i;
    int          idl;
    x = r[15:0];
    q = {r[79:72], r[71:64], r[63:56], r[55:48], r[47:40], r[39:32]};
    if (r[71:64] == 8'h10) q = {q, 8'h02, x[15:8], x[7:0]};
    busy = r[31:28] == 4'h3;
    exec_fail = r[31:28] == 4'h4;
    case (r[27:24])
      4'h1: e = q;
      4'h2: e = {q[0], q[1], 8'h02, x[15:8], x[7:0]};
      4'h3: e = {q[0], q[1] | 8'h80, x[7:0]};
      default: e = {};
    endcase
    c = m.crc16(e);
    if (e.size() > 0) e = {e, c[7:0], c[15:8]};
    m.got.delete();
    m.send(q, r[31:28]);
    idl = 0;
    // Forty idle cycles outlast the gap, so the next frame is legal
    for (i = 0; i < 400 && idl < 40; i++) begin
      @(negedge sys_clk);
      idl = tx_valid ? 0 : idl + 1;
    end
    if (i == 400) begin
      n_errors++;
      close_out();
    end
    chkf(e);
  endtask
  initial begin
    for (int k = 0; k < 11; k++)
      status_words[16*k +: 16] = 16'h2100 + 16'(k);
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    chk(crc_error_counter, 16'h0000);
    chk(16'(forward_rotation), 16'h0001);
    repeat (GAP + 5) @(negedge sys_clk);
    chk(m.crc16('{8'h01, 8'h06, 8'h08, 8'h02, 8'h00, 8'h01}),
        16'hAAEB);
    foreach (ROWS[j]) begin
      m.slow = j % 2;
      xfer(ROWS[j]);
    end
    chk(16'(comm_length_fault), 16'h0001);
    chk(crc_error_counter, 16'h0001);
    chk(process_data_out[15:0], 16'h0003);
    chk(process_data_out[31:16], 16'h1234);
    chk(speed_setpoint, 16'h2710);
    chk(16'(run_cmd && reverse_rotation), 16'h0001);
    relay1_function_select = 8'h1C;
    stop_mode_setting = 1'b1;
    xfer(80'h0106_07D0_2000_0100_0000);
    chk(16'(relay_output_1), 16'h0001);
    chk(16'(stop_mode), 16'h0001);
    xfer(80'h0106_07D0_1011_0100_0000);
    chk(16'(inverter_block && !run_cmd), 16'h0001);
    chk(16'(stop_mode), 16'h0000);
    // Fault reset, fast ramp, freeze and both bus overrides at once
    xfer(80'h0106_07D0_0364_0100_0000);
    chk(16'(comm_length_fault), 16'h0000);
    chk({13'h0000, fast_ramp, force_bus_control, force_bus_setpoint},
        16'h0007);
    xfer(80'h0106_07D2_0100_0100_0000);
    chk(speed_setpoint, 16'h2710);
    m.slow = 0;
    m.got.delete();
    m.send('{8'h01, 8'h03, 8'h07, 8'hD0, 8'h00, 8'h01}, 4'h0);
    for (int k = 0; k < 300 && m.got.size() < 7; k++) @(negedge sys_clk);
    chk(16'(m.got.size()), 16'h0007);
    xfer(80'h0103_07D0_0001_0000_0000);
    xfer(80'h0103_07D0_0001_0200_0364);
    close_out();
  end
endmodule
bind modbus_rtu_slave_handler slave_handler_asserts #(
  .GAP_CYCLES(GAP_CYCLES), .NREGS(NREGS)) chk_u (
  .sys_clk, .rst, .ce, .station_address, .rx_data, .rx_valid, .tx_data,
  .tx_valid, .tx_ready, .stop_mode_setting, .crc_error_counter,
  .process_data_out, .forward_rotation, .reverse_rotation, .stop_mode);
